// [hdl/reset_source_controller.sv]
`timescale 1ns/1ns
`default_nettype none
`include "reset_source_controller_defines.svh"

module reset_source_controller
    import reset_source_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    // special-function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // asynchronous sources
    input wire logic reset_pin_n_in,
    input wire logic supply_ok_in,
    input wire logic clock_loss_timeout_in,
    input wire logic comparator_out_in,
    // same-clock sources
    input wire logic watchdog_update_in,
    input wire logic watchdog_disable_in,
    input wire logic program_store_write_enable_in,
    input wire logic data_move_write_in,
    input wire logic [15:0] data_move_addr_in,
    input wire logic code_read_in,
    input wire logic [15:0] code_read_addr_in,
    input wire logic fetch_branch_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic flash_security_block_in,
    // results
    output logic system_reset_n_out,
    output logic clock_loss_detector_enable_out,
    output logic watchdog_enabled_out
);

    // rounded up so an internal reset never runs short of its nominal time
    localparam int HOLD_CYCLES =
        (`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int WDOG_DIV_LAST = `WATCHDOG_DIV - 1;

    seq_state_t state_reg;
    seq_state_t state_next;
    cause_flags_t flags_reg;
    cause_flags_t cause_vec;

    logic pin_meta_reg;
    logic pin_sync_reg;
    logic supply_meta_reg;
    logic supply_sync_reg;
    logic loss_meta_reg;
    logic loss_sync_reg;
    logic cmp_meta_reg;
    logic cmp_sync_reg;

    logic clock_loss_en_reg;
    logic comparator_en_reg;
    logic supply_src_en_reg;
    logic [2:0] hold_cnt_reg;
    logic system_reset_n_reg;
    logic [7:0] rdata_reg;

    logic wdog_en_reg;
    logic [3:0] wdog_div_reg;
    logic [7:0] wdog_cnt_reg;
    logic wdog_tick;
    logic wdog_overflow;

    logic pin_low;
    logic supply_trip;
    logic loss_trip;
    logic cmp_trip;
    logic flash_fault;
    logic sfr_hit_wr;
    logic soft_req;
    logic in_run;
    logic hold_done;

    // two-stage synchronisers for everything not on clk_in
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            supply_meta_reg <= 1'b1;
            supply_sync_reg <= 1'b1;
            loss_meta_reg <= 1'b0;
            loss_sync_reg <= 1'b0;
            cmp_meta_reg <= 1'b1;
            cmp_sync_reg <= 1'b1;
        end else begin
            pin_meta_reg <= reset_pin_n_in;
            pin_sync_reg <= pin_meta_reg;
            supply_meta_reg <= supply_ok_in;
            supply_sync_reg <= supply_meta_reg;
            loss_meta_reg <= clock_loss_timeout_in;
            loss_sync_reg <= loss_meta_reg;
            cmp_meta_reg <= comparator_out_in;
            cmp_sync_reg <= cmp_meta_reg;
        end
    end

    // pin, flash and software resets are always live; the other sources can be switched off
    assign in_run = (state_reg == ST_RUN);
    assign pin_low = ~pin_sync_reg;
    assign supply_trip = supply_src_en_reg & ~supply_sync_reg;
    // the one-shot itself is analog and retriggers on every clk_in edge;
    // only its timeout is seen here
    assign loss_trip = clock_loss_en_reg & loss_sync_reg;
    assign cmp_trip = comparator_en_reg & ~cmp_sync_reg;

    // flash requests come from the core on this clock, so no synchroniser here
    always_comb begin
        flash_fault = 1'b0;
        if (program_store_write_enable_in && data_move_write_in &&
            (data_move_addr_in > `FLASH_TOP_ADDR)) begin
            flash_fault = 1'b1;
        end
        if (code_read_in && (code_read_addr_in > `FLASH_TOP_ADDR)) begin
            flash_fault = 1'b1;
        end
        if (fetch_branch_in && (fetch_addr_in > `FLASH_TOP_ADDR)) begin
            flash_fault = 1'b1;
        end
        if (flash_security_block_in) begin
            flash_fault = 1'b1;
        end
    end

    // writes during reset are dropped: the clock-loss and comparator enables are being cleared then
    assign sfr_hit_wr = sfr_wr_in && (sfr_addr_in == `RESET_CAUSE_ADDR);
    assign soft_req = sfr_hit_wr && sfr_wdata_in[`SOFTWARE_BIT];

    // one cause per reset; earlier lines win a tie
    // supply first: after a brown-out no other cause can be trusted
    always_comb begin
        cause_vec = '0;
        if (supply_trip) begin
            cause_vec[`POWER_FLAG_BIT] = 1'b1;
        end else if (loss_trip) begin
            cause_vec[`CLOCK_LOSS_BIT] = 1'b1;
        end else if (flash_fault) begin
            cause_vec[`FLASH_FAULT_BIT] = 1'b1;
        end else if (wdog_overflow) begin
            cause_vec[`WATCHDOG_FLAG_BIT] = 1'b1;
        end else if (cmp_trip) begin
            cause_vec[`COMPARATOR_BIT] = 1'b1;
        end else if (soft_req) begin
            cause_vec[`SOFTWARE_BIT] = 1'b1;
        end
    end

    // three bits cover the hold; a longer hold needs a wider counter
    assign hold_done = (hold_cnt_reg == 3'(HOLD_CYCLES - 1));

    // the pin overrides everything, even a hold already under way
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (pin_low) begin
                    state_next = ST_PIN;
                end else if (cause_vec != '0) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (pin_low) begin
                    state_next = ST_PIN;
                end else if (hold_done && !supply_trip) begin
                    state_next = ST_RUN;
                end
            end
            ST_PIN: begin
                if (!pin_low) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // power-on starts in hold so it leaves through the same path as every cause but the pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // supply dips keep the hold counter at zero until power recovers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hold_cnt_reg <= 3'h0;
        end else if (state_reg != ST_HOLD || supply_trip) begin
            hold_cnt_reg <= 3'h0;
        end else if (!hold_done) begin
            hold_cnt_reg <= hold_cnt_reg + 3'h1;
        end
    end

    // registered so the reset line never glitches on decode
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            system_reset_n_reg <= 1'b0;
        end else begin
            system_reset_n_reg <= (state_next == ST_RUN);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_reg <= `CAUSE_POR_VALUE;
        end else if (in_run && state_next == ST_PIN) begin
            flags_reg <= '0;
        end else if (state_reg == ST_PIN && state_next == ST_RUN) begin
            flags_reg <= cause_flags_t'(1) << `PIN_FLAG_BIT;
        end else if (in_run && state_next == ST_HOLD) begin
            flags_reg <= cause_vec;
        end else if (state_reg == ST_HOLD && supply_trip) begin
            // a supply dip inside another hold still counts as a power reset
            flags_reg <= cause_flags_t'(1) << `POWER_FLAG_BIT;
        end
    end

    // enables change only while running; reset drops the switchable
    // sources, but supply-source selection survives all but power-on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clock_loss_en_reg <= 1'b0;
            comparator_en_reg <= 1'b0;
            supply_src_en_reg <= 1'b1;
        end else if (!in_run || state_next != ST_RUN) begin
            clock_loss_en_reg <= 1'b0;
            comparator_en_reg <= 1'b0;
        end else if (sfr_hit_wr) begin
            clock_loss_en_reg <= sfr_wdata_in[`CLOCK_LOSS_BIT];
            comparator_en_reg <= sfr_wdata_in[`COMPARATOR_BIT];
            supply_src_en_reg <= sfr_wdata_in[`POWER_FLAG_BIT];
        end
    end

    // watchdog prescaler and counter
    // overflow counts only while enabled; a disabled watchdog holds at zero
    assign wdog_tick = (wdog_div_reg == 4'(WDOG_DIV_LAST));
    assign wdog_overflow = wdog_en_reg && wdog_tick &&
        (wdog_cnt_reg == `WATCHDOG_LIMIT);

    // software may switch the watchdog off, but every reset turns it back on
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdog_en_reg <= 1'b1;
        end else if (!system_reset_n_reg) begin
            wdog_en_reg <= 1'b1;
        end else if (watchdog_disable_in) begin
            wdog_en_reg <= 1'b0;
        end
    end

    // prescaler phase restarts in reset, so the first tick comes a full period late
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdog_div_reg <= 4'h0;
        end else if (!system_reset_n_reg || wdog_tick) begin
            wdog_div_reg <= 4'h0;
        end else begin
            wdog_div_reg <= wdog_div_reg + 4'h1;
        end
    end

    // the count parks at its limit; the next tick there is the overflow
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdog_cnt_reg <= 8'h00;
        end else if (!system_reset_n_reg || !wdog_en_reg) begin
            wdog_cnt_reg <= 8'h00;
        end else if (watchdog_update_in) begin
            wdog_cnt_reg <= 8'h00;
        end else if (wdog_tick && wdog_cnt_reg != `WATCHDOG_LIMIT) begin
            wdog_cnt_reg <= wdog_cnt_reg + 8'h01;
        end
    end

    // read data: bit 7 is constant zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 8'h00;
        end else if (sfr_rd_in && sfr_addr_in == `RESET_CAUSE_ADDR) begin
            rdata_reg <= {1'b0, flags_reg};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // no pin driver exists here: internal resets leave the pin alone
    assign system_reset_n_out = system_reset_n_reg;
    assign sfr_rdata_out = rdata_reg;
    assign clock_loss_detector_enable_out = clock_loss_en_reg;
    assign watchdog_enabled_out = wdog_en_reg;

endmodule // reset_source_controller

`default_nettype wire

// [shared/reset_source_controller_defines.svh]
`ifndef RESET_SOURCE_CONTROLLER_DEFINES_SVH
`define RESET_SOURCE_CONTROLLER_DEFINES_SVH

`define RESET_CAUSE_ADDR 8'hef
`define PIN_FLAG_BIT 0
`define POWER_FLAG_BIT 1
`define CLOCK_LOSS_BIT 2
`define WATCHDOG_FLAG_BIT 3
`define SOFTWARE_BIT 4
`define COMPARATOR_BIT 5
`define FLASH_FAULT_BIT 6
`define CAUSE_POR_VALUE 7'h02
`define FLASH_TOP_ADDR 16'h3dff
`define CLK_PERIOD_NS 50
`define RESET_HOLD_NS 200
`define WATCHDOG_DIV 12
`define WATCHDOG_LIMIT 8'hff

`endif

// [shared/reset_source_pkg.sv]
package reset_source_pkg;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD,
        ST_PIN
    } seq_state_t;

    typedef logic [6:0] cause_flags_t;

endpackage

// [tb/reset_source_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module reset_source_partner (
    input wire logic pin_low_in,
    input wire logic clock_stop_in,
    input wire logic cmp_trip_in,
    input wire logic detector_enable_in,
    input wire logic supply_dip_in,
    output logic reset_pin_n_out,
    output logic supply_ok_out,
    output logic clock_loss_timeout_out,
    output logic comparator_out_out
);
    // pull-up brings the pin back high as soon as the outside lets go
    assign reset_pin_n_out = !pin_low_in;
    assign supply_ok_out = !supply_dip_in;
    // one-shot only times out while enabled and starved of clock edges
    assign clock_loss_timeout_out = detector_enable_in && clock_stop_in;
    assign comparator_out_out = !cmp_trip_in;
endmodule // reset_source_partner
`default_nettype wire

// [tb/reset_source_controller_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "reset_source_controller_defines.svh"
module reset_source_controller_properties (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic reset_pin_n_in,
    input wire logic clock_loss_timeout_in,
    input wire logic program_store_write_enable_in,
    input wire logic data_move_write_in,
    input wire logic [15:0] data_move_addr_in,
    input wire logic code_read_in,
    input wire logic [15:0] code_read_addr_in,
    input wire logic fetch_branch_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic flash_security_block_in,
    input wire logic system_reset_n_out,
    input wire logic clock_loss_detector_enable_out,
    input wire logic watchdog_enabled_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic wr_ef;
    assign wr_ef = sfr_wr_in && sfr_addr_in == `RESET_CAUSE_ADDR && system_reset_n_out;
    property p_sw;
        wr_ef && sfr_wdata_in[4] |=> !system_reset_n_out [*4] ##1 system_reset_n_out;
    endproperty
    a_sw: assert property (p_sw) else $error("software reset length wrong");
    property p_bit7;
        sfr_rdata_out[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 read as one");
    property p_wdog;
        $rose(system_reset_n_out) |-> watchdog_enabled_out;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog off after reset");
    property p_pin;
        $fell(reset_pin_n_in) |-> ##[1:4] !system_reset_n_out;
    endproperty
    a_pin: assert property (p_pin) else $error("pin low gave no reset");
    property p_loss;
        system_reset_n_out && clock_loss_detector_enable_out && clock_loss_timeout_in |-> ##[1:4] !system_reset_n_out;
    endproperty
    a_loss: assert property (p_loss) else $error("clock loss gave no reset");
    property p_loss_en;
        wr_ef && !sfr_wdata_in[4] |=> clock_loss_detector_enable_out == $past(sfr_wdata_in[2]);
    endproperty
    a_loss_en: assert property (p_loss_en) else $error("detector enable not written");
    property p_dmw;
        system_reset_n_out && program_store_write_enable_in && data_move_write_in && data_move_addr_in > `FLASH_TOP_ADDR
            |=> !system_reset_n_out;
    endproperty
    a_dmw: assert property (p_dmw) else $error("illegal flash write gave no reset");
    property p_fl;
        system_reset_n_out && (code_read_in && code_read_addr_in > `FLASH_TOP_ADDR || fetch_branch_in &&
            fetch_addr_in > `FLASH_TOP_ADDR || flash_security_block_in) |=> !system_reset_n_out;
    endproperty
    a_fl: assert property (p_fl) else $error("flash fault gave no reset");
    c_sw: cover property (wr_ef && sfr_wdata_in[4]);
    c_pin: cover property ($fell(reset_pin_n_in));
    c_dmw: cover property (system_reset_n_out && data_move_write_in && program_store_write_enable_in);
endmodule // reset_source_controller_properties
bind reset_source_controller reset_source_controller_properties u_props (.clk_in, .rst_n_in, .sfr_addr_in,
    .sfr_wr_in, .sfr_wdata_in, .sfr_rdata_out, .reset_pin_n_in, .clock_loss_timeout_in,
    .program_store_write_enable_in, .data_move_write_in, .data_move_addr_in, .code_read_in, .code_read_addr_in,
    .fetch_branch_in, .fetch_addr_in, .flash_security_block_in, .system_reset_n_out,
    .clock_loss_detector_enable_out, .watchdog_enabled_out);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0, pin_low = 1'b0, stop = 1'b0, trip = 1'b0;
    logic wdu = 1'b0, wdd = 1'b0, pse = 1'b0, dmw = 1'b0, crd = 1'b0, fbr = 1'b0, sec = 1'b0, dip = 1'b0;
    logic [7:0] addr = 8'hef, wd = 8'h00, rdata;
    logic [15:0] fa = 16'h0000;
    logic sys_n, loss_en, wd_en, pin_n, sok, tmo, cmp;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #25 clk_in = !clk_in;
    reset_source_partner u_reset_source_partner (.pin_low_in(pin_low), .clock_stop_in(stop), .cmp_trip_in(trip),
        .detector_enable_in(loss_en), .supply_dip_in(dip), .reset_pin_n_out(pin_n), .supply_ok_out(sok),
        .clock_loss_timeout_out(tmo), .comparator_out_out(cmp));
    reset_source_controller u_reset_source_controller (.clk_in, .rst_n_in, .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdata), .reset_pin_n_in(pin_n), .supply_ok_in(sok),
        .clock_loss_timeout_in(tmo), .comparator_out_in(cmp), .watchdog_update_in(wdu),
        .watchdog_disable_in(wdd), .program_store_write_enable_in(pse), .data_move_write_in(dmw),
        .data_move_addr_in(fa), .code_read_in(crd), .code_read_addr_in(fa), .fetch_branch_in(fbr),
        .fetch_addr_in(fa), .flash_security_block_in(sec), .system_reset_n_out(sys_n),
        .clock_loss_detector_enable_out(loss_en), .watchdog_enabled_out(wd_en));
    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic write(input logic [7:0] d);
        @(negedge clk_in);
        wr = 1'b1;
        wd = d;
        @(negedge clk_in);
        wr = 1'b0;
    endtask
    task automatic read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_in);
        addr = a;
        rd = 1'b1;
        @(negedge clk_in);
        rd = 1'b0;
        addr = 8'hef;
        check(rdata, exp);
    endtask
    // waits out one whole reset, then reads back the cause flags
    task automatic rst_cycle(input logic [7:0] flags, input int lim);
        for (int i = 0; i < lim && sys_n !== 1'b0; i++) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h00);
        for (int i = 0; i < 60 && sys_n !== 1'b1; i++) @(negedge clk_in);
        check({7'h00, wd_en}, 8'h01);
        read(8'hef, flags);
    endtask
    task automatic flash(input int k, input logic [15:0] a);
        @(negedge clk_in);
        fa = a;
        {pse, dmw, crd, fbr, sec} = {k == 0, k == 0, k == 1, k == 2, k == 3};
        @(negedge clk_in);
        {pse, dmw, crd, fbr, sec} = 5'h00;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic scen_power_on();
        rst_cycle(8'h02, 30);
    endtask
    // read-only bits ignore the write; other addresses read zero
    task automatic scen_register();
        write(8'hcb);
        read(8'hef, 8'h02);
        read(8'hee, 8'h00);
    endtask
    task automatic scen_software();
        write(8'h12);
        rst_cycle(8'h10, 30);
    endtask
    task automatic scen_pin();
        pin_low = 1'b1;
        repeat (8) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h00);
        pin_low = 1'b0;
        rst_cycle(8'h01, 30);
    endtask
    task automatic scen_clock_loss();
        write(8'h06);
        write(8'h02);
        check({7'h00, loss_en}, 8'h00);
        write(8'h06);
        check({7'h00, loss_en}, 8'h01);
        stop = 1'b1;
        rst_cycle(8'h04, 30);
        stop = 1'b0;
    endtask
    task automatic scen_comparator();
        // comparator already settled high before it is armed
        write(8'h22);
        repeat (5) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h01);
        trip = 1'b1;
        rst_cycle(8'h20, 30);
        trip = 1'b0;
    endtask
    // a dip holds reset until the supply is back; masked, it does nothing
    task automatic scen_supply();
        dip = 1'b1;
        repeat (10) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h00);
        dip = 1'b0;
        rst_cycle(8'h02, 30);
        write(8'h00);
        dip = 1'b1;
        repeat (6) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h01);
        dip = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic scen_flash();
        for (int k = 0; k < 4; k++) begin
            if (k < 3) begin
                flash(k, 16'h3dff);
                check({7'h00, sys_n}, 8'h01);
            end
            flash(k, 16'h3e00);
            rst_cycle(8'h40, 30);
        end
    endtask
    // overflow lands 3061 to 3072 cycles after the last update, on a twelve-cycle tick
    task automatic scen_watchdog();
        repeat (4) begin
            repeat (2000) @(negedge clk_in);
            wdu = 1'b1;
            @(negedge clk_in);
            wdu = 1'b0;
        end
        repeat (3060) @(negedge clk_in);
        check({7'h00, sys_n}, 8'h01);
        rst_cycle(8'h08, 12);
    endtask
    task automatic scen_watchdog_off();
        wdd = 1'b1;
        @(negedge clk_in);
        wdd = 1'b0;
        @(negedge clk_in);
        check({7'h00, wd_en}, 8'h00);
        write(8'h12);
        rst_cycle(8'h10, 30);
    endtask
    initial begin
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        scen_power_on();
        scen_register();
        scen_software();
        scen_pin();
        scen_clock_loss();
        scen_comparator();
        scen_supply();
        scen_flash();
        scen_watchdog();
        scen_watchdog_off();
        final_report();
    end
endmodule // tb
`default_nettype wire
